// ===== rtl/stsfs_seq_rx.sv
// Receiving sequencer end: tracks byte position, classifies bytes, follows the pointer
`timescale 1ns/1ps
`default_nettype none
`include "stsfs_defines.svh"

// Functional notes
// - Frame holds exactly 810 bytes, 6480 bits.
// - Index bytes as 9 rows of 90.
// - Frames repeat 8000 times per second.
// - Frame starts row one column one, ends row nine column ninety.
// - Top row first, left to right.
// - After last column, next row's first byte.
// - Next frame follows last byte without gap.
// - First three columns are transport overhead.
// - Recognise pointer bytes and pointer action byte.
// - Pointer locates envelope start in capacity.
// - Report pointer adjustments and new data flags.
// - Other 87 columns are envelope capacity.
// - Track floating 87 by 9 envelope.
// - Envelope first column path overhead, rest payload.
module stsfs_seq_rx
  import stsfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  stsfs_link_if.seq link,
  output logic [7:0] byte_out,
  output logic byte_valid_out,
  output logic sof_out,
  output logic [3:0] row_out,
  output logic [6:0] col_out,
  output logic toh_out,
  output logic h1_out,
  output logic h2_out,
  output logic h3_out,
  output logic envelope_out,
  output logic poh_out,
  output logic payload_out,
  output logic ptr_locked_out,
  output logic [9:0] ptr_out,
  output logic inc_out,
  output logic dec_out,
  output logic ndf_out,
  output logic frame_err_out
);

  stsfs_row_t cnt_row;
  stsfs_col_t cnt_col;
  stsfs_row_t cur_row;
  stsfs_col_t cur_col;
  logic take;
  logic restart;
  logic cur_toh;
  logic cur_h1;
  logic cur_h2;
  logic cur_h3;
  logic cur_env;
  stsfs_ptr_t cur_ec;
  stsfs_byte_t h1_hold;
  stsfs_ptr_state_e ptr_state;
  stsfs_ptr_state_e next_ptr_state;
  stsfs_ptr_t ptr;
  stsfs_ptr_t next_ptr;
  stsfs_ptr_t rx_value;
  logic [3:0] rx_ndf;
  logic ndf_set;
  logic ndf_norm;
  logic value_ok;
  logic inc_ev;
  logic dec_ev;
  logic ndf_ev;
  logic ptr_load;
  stsfs_col_t spe_col;
  stsfs_col_t cur_spe_col;
  logic spe_found;
  logic j1_hit;
  logic cur_poh;
  logic spe_now;

  // New data flag majority: at least three of four bits match
  function automatic logic ndf_match(input logic [3:0] f, input logic [3:0] code);
    logic [3:0] same;
    same = ~(f ^ code);
    return 3'(same[0]) + 3'(same[1]) + 3'(same[2]) + 3'(same[3]) >= 3'h3;
  endfunction : ndf_match

  ////////////////////////////////////////////////////////////////////////////
  // Position tracking; a start marker realigns to the origin
  assign take = link.valid;
  assign restart = link.valid && link.sof;
  assign cur_row = restart ? 4'h0 : cnt_row;
  assign cur_col = restart ? 7'h00 : cnt_col;

  stsfs_frame_counter u_cnt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .adv_in(take),
    .restart_in(restart),
    .row_out(cnt_row),
    .col_out(cnt_col),
    .wrap_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte classification by position
  assign cur_toh = stsfs_is_toh(cur_col);
  assign cur_env = !cur_toh;
  assign cur_h1 = stsfs_is_ptr_byte(cur_row, cur_col, `STSFS_H1_COL);
  assign cur_h2 = stsfs_is_ptr_byte(cur_row, cur_col, `STSFS_H2_COL);
  assign cur_h3 = stsfs_is_ptr_byte(cur_row, cur_col, `STSFS_H3_COL);
  assign cur_ec = stsfs_ec_index(cur_row, cur_col);

  // Hold the first pointer byte until its partner arrives
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      h1_hold <= 8'h00;
    end else if (take && cur_h1) begin
      h1_hold <= link.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer interpretation at the second pointer byte
  assign rx_value = {h1_hold[1:0], link.data};
  assign rx_ndf = h1_hold[7:4];
  assign ndf_set = ndf_match(rx_ndf, `STSFS_NDF_SET);
  assign ndf_norm = ndf_match(rx_ndf, `STSFS_NDF_NORMAL);
  assign value_ok = rx_value <= `STSFS_PTR_MAX;

  always_comb begin
    next_ptr_state = ptr_state;
    next_ptr = ptr;
    inc_ev = 1'b0;
    dec_ev = 1'b0;
    ndf_ev = 1'b0;
    ptr_load = 1'b0;
    if (take && cur_h2) begin
      unique case (ptr_state)
        STSFS_PTR_ACQ: begin
          if ((ndf_set || ndf_norm) && value_ok) begin
            next_ptr = rx_value;
            next_ptr_state = STSFS_PTR_LOCK;
            ndf_ev = ndf_set;
            ptr_load = 1'b1;
          end
        end
        STSFS_PTR_LOCK: begin
          if (ndf_set && value_ok) begin
            next_ptr = rx_value;
            ndf_ev = 1'b1;
            ptr_load = 1'b1;
          end else if (ndf_norm &&
                       stsfs_ones((rx_value ^ ptr) & `STSFS_I_MASK) >= 4'h3) begin
            next_ptr = (ptr == `STSFS_PTR_MAX) ? 10'h000 : 10'(ptr + 10'h001);
            inc_ev = 1'b1;
            ptr_load = 1'b1;
          end else if (ndf_norm &&
                       stsfs_ones((rx_value ^ ptr) & `STSFS_D_MASK) >= 4'h3) begin
            next_ptr = (ptr == 10'h000) ? `STSFS_PTR_MAX : 10'(ptr - 10'h001);
            dec_ev = 1'b1;
            ptr_load = 1'b1;
          end
        end
      endcase
    end
  end

  // Pointer state and value
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr_state <= STSFS_PTR_ACQ;
      ptr <= 10'h000;
    end else begin
      ptr_state <= next_ptr_state;
      ptr <= next_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Floating envelope column tracking
  assign j1_hit = (ptr_state == STSFS_PTR_LOCK) && cur_env && (cur_ec == ptr);
  assign cur_spe_col = j1_hit ? 7'h00 : spe_col;
  // Envelope start seen since the last pointer load, this byte included
  assign spe_now = j1_hit || spe_found;
  assign cur_poh = spe_now && cur_env && (cur_spe_col == 7'h00);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      spe_col <= 7'h00;
      spe_found <= 1'b0;
    end else if (ptr_load) begin
      spe_found <= 1'b0;
    end else if (take && cur_env) begin
      spe_found <= spe_now;
      spe_col <= (cur_spe_col == `STSFS_EC_LAST_COL) ? 7'h00 : 7'(cur_spe_col + 7'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered per-byte outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      byte_out <= 8'h00;
      byte_valid_out <= 1'b0;
      sof_out <= 1'b0;
      row_out <= 4'h0;
      col_out <= 7'h00;
      toh_out <= 1'b0;
      h1_out <= 1'b0;
      h2_out <= 1'b0;
      h3_out <= 1'b0;
      envelope_out <= 1'b0;
      poh_out <= 1'b0;
      payload_out <= 1'b0;
    end else begin
      byte_out <= take ? link.data : 8'h00;
      byte_valid_out <= take;
      sof_out <= take && cur_row == 4'h0 && cur_col == 7'h00;
      row_out <= cur_row;
      col_out <= cur_col;
      toh_out <= take && cur_toh;
      h1_out <= take && cur_h1;
      h2_out <= take && cur_h2;
      h3_out <= take && cur_h3;
      envelope_out <= take && cur_env;
      poh_out <= take && cur_poh;
      payload_out <= take && cur_env && spe_now && !cur_poh;
    end
  end

  // Pointer status and event pulses
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr_locked_out <= 1'b0;
      ptr_out <= 10'h000;
      inc_out <= 1'b0;
      dec_out <= 1'b0;
      ndf_out <= 1'b0;
    end else begin
      ptr_locked_out <= next_ptr_state == STSFS_PTR_LOCK;
      ptr_out <= next_ptr;
      inc_out <= inc_ev;
      dec_out <= dec_ev;
      ndf_out <= ndf_ev;
    end
  end

  // Frame length check: start marker only at the origin, and never missing there
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_err_out <= 1'b0;
    end else begin
      frame_err_out <= take && ((link.sof && (cnt_row != 4'h0 || cnt_col != 7'h00)) ||
                                (!link.sof && cnt_row == 4'h0 && cnt_col == 7'h00));
    end
  end

endmodule : stsfs_seq_rx

`default_nettype wire

// ===== shared/stsfs_defines.svh
// Frame geometry, pointer codes and timing constants for the STS-1 frame sequencer
`ifndef STSFS_DEFINES_SVH
`define STSFS_DEFINES_SVH

// Frame geometry
`define STSFS_FRAME_BYTES 10'h32A
`define STSFS_FRAME_BITS 13'h1950
`define STSFS_ROWS 4'h9
`define STSFS_COLS 7'h5A
`define STSFS_LAST_ROW 4'h8
`define STSFS_LAST_COL 7'h59
`define STSFS_TOH_COLS 7'h03
`define STSFS_EC_COLS 7'h57
`define STSFS_EC_LAST_COL 7'h56
`define STSFS_EC_BYTES 10'h30F

// Pointer bytes sit in row four, columns one to three (zero based row 3)
`define STSFS_PTR_ROW 4'h3
`define STSFS_H1_COL 7'h00
`define STSFS_H2_COL 7'h01
`define STSFS_H3_COL 7'h02
`define STSFS_PTR_MAX 10'h30E

// Pointer word field codes
`define STSFS_NDF_NORMAL 4'h6
`define STSFS_NDF_SET 4'h9
`define STSFS_H3_IDLE 8'h00
`define STSFS_I_MASK 10'h2AA
`define STSFS_D_MASK 10'h155

// Framing pattern bytes and idle overhead
`define STSFS_FRAME_A1 8'hF6
`define STSFS_FRAME_A2 8'h28
`define STSFS_TOH_IDLE 8'h00

// Timing: 8000 frames per second on a 40 MHz clock
`define STSFS_CLK_HZ 32'h0262_5A00
`define STSFS_FRAME_RATE_HZ 32'h0000_1F40
`define STSFS_FRAME_CYCLES (`STSFS_CLK_HZ / `STSFS_FRAME_RATE_HZ)

`endif

// ===== shared/stsfs_pkg.sv
// Types and shared helper functions for the STS-1 frame sequencer
`include "stsfs_defines.svh"

package stsfs_pkg;

  typedef logic [3:0] stsfs_row_t;
  typedef logic [6:0] stsfs_col_t;
  typedef logic [9:0] stsfs_ptr_t;
  typedef logic [7:0] stsfs_byte_t;

  typedef enum logic [0:0] {
    STSFS_PTR_ACQ = 1'b0,
    STSFS_PTR_LOCK = 1'b1
  } stsfs_ptr_state_e;

  // Byte lies in the transport overhead columns
  function automatic logic stsfs_is_toh(input stsfs_col_t col);
    return col < `STSFS_TOH_COLS;
  endfunction : stsfs_is_toh

  // Byte is one of the pointer bytes at the given column
  function automatic logic stsfs_is_ptr_byte(input stsfs_row_t row, input stsfs_col_t col,
                                             input stsfs_col_t which);
    return (row == `STSFS_PTR_ROW) && (col == which);
  endfunction : stsfs_is_ptr_byte

  // Offset of an envelope byte counted from the byte after the action byte
  function automatic stsfs_ptr_t stsfs_ec_index(input stsfs_row_t row, input stsfs_col_t col);
    logic [3:0] r;
    logic [9:0] prod;
    r = (row >= `STSFS_PTR_ROW) ? 4'(row - `STSFS_PTR_ROW) : 4'(row + 4'h6);
    prod = 10'(r * `STSFS_EC_COLS);
    return 10'(prod + 10'(col) - 10'(`STSFS_TOH_COLS));
  endfunction : stsfs_ec_index

  // Ones count of a pointer sized word
  function automatic logic [3:0] stsfs_ones(input stsfs_ptr_t v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = 4'(n + 4'(v[i]));
    end
    return n;
  endfunction : stsfs_ones

endpackage : stsfs_pkg

// ===== shared/stsfs_link_if.sv
// Byte stream link between a SONET network element and the frame sequencer
`timescale 1ns/1ps
`default_nettype none

interface stsfs_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [7:0] data;
  logic valid;
  logic sof;

  // Transmitting network element
  modport ne (
    input clk,
    input rst_n,
    output data,
    output valid,
    output sof
  );

  // Receiving sequencer
  modport seq (
    input clk,
    input rst_n,
    input data,
    input valid,
    input sof
  );
endinterface : stsfs_link_if

`default_nettype wire

// ===== rtl/stsfs_frame_counter.sv
// Row and column position counter for the 9 by 90 byte frame array
`timescale 1ns/1ps
`default_nettype none
`include "stsfs_defines.svh"

module stsfs_frame_counter
  import stsfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic adv_in,
  input wire logic restart_in,
  output logic [3:0] row_out,
  output logic [6:0] col_out,
  output logic wrap_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Position register, row one column one after reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      row_out <= 4'h0;
      col_out <= 7'h00;
    end else if (adv_in) begin
      if (restart_in) begin
        row_out <= 4'h0;
        col_out <= 7'h01;
      end else if (col_out == `STSFS_LAST_COL) begin
        col_out <= 7'h00;
        row_out <= (row_out == `STSFS_LAST_ROW) ? 4'h0 : 4'(row_out + 4'h1);
      end else begin
        col_out <= 7'(col_out + 7'h01);
      end
    end
  end

  // Last byte of the frame
  assign wrap_out = (row_out == `STSFS_LAST_ROW) && (col_out == `STSFS_LAST_COL);

endmodule : stsfs_frame_counter

`default_nettype wire

// ===== rtl/stsfs_ne_tx.sv
// Transmitting network element end: paces and emits STS-1 frames onto the link
`timescale 1ns/1ps
`default_nettype none
`include "stsfs_defines.svh"

module stsfs_ne_tx
  import stsfs_pkg::*;
#(
  parameter int FRAME_CYCLES = `STSFS_FRAME_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  stsfs_link_if.ne link,
  input wire logic [7:0] payload_in,
  input wire logic [9:0] ptr_in,
  input wire logic ndf_in,
  output logic take_out
);

  logic [12:0] acc;
  logic [13:0] next_sum;
  logic strobe;
  stsfs_row_t row;
  stsfs_col_t col;
  stsfs_byte_t next_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Fractional pacing: 810 byte strobes per FRAME_CYCLES clocks
  assign next_sum = 14'(acc) + 14'(`STSFS_FRAME_BYTES);
  assign strobe = next_sum >= 14'(FRAME_CYCLES);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acc <= 13'h0000;
    end else begin
      acc <= strobe ? 13'(next_sum - 14'(FRAME_CYCLES)) : 13'(next_sum);
    end
  end

  // Position in the outgoing frame
  stsfs_frame_counter u_cnt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .adv_in(strobe),
    .restart_in(1'b0),
    .row_out(row),
    .col_out(col),
    .wrap_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte selection by position
  always_comb begin
    next_byte = payload_in;
    if (stsfs_is_toh(col)) begin
      next_byte = `STSFS_TOH_IDLE;
      if (row == 4'h0 && col == 7'h00) begin
        next_byte = `STSFS_FRAME_A1;
      end else if (row == 4'h0 && col == 7'h01) begin
        next_byte = `STSFS_FRAME_A2;
      end else if (stsfs_is_ptr_byte(row, col, `STSFS_H1_COL)) begin
        next_byte = {(ndf_in ? `STSFS_NDF_SET : `STSFS_NDF_NORMAL), 2'b00, ptr_in[9:8]};
      end else if (stsfs_is_ptr_byte(row, col, `STSFS_H2_COL)) begin
        next_byte = ptr_in[7:0];
      end else if (stsfs_is_ptr_byte(row, col, `STSFS_H3_COL)) begin
        next_byte = `STSFS_H3_IDLE;
      end
    end
  end

  // Registered link outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link.data <= 8'h00;
      link.valid <= 1'b0;
      link.sof <= 1'b0;
      take_out <= 1'b0;
    end else begin
      link.data <= strobe ? next_byte : 8'h00;
      link.valid <= strobe;
      link.sof <= strobe && row == 4'h0 && col == 7'h00;
      take_out <= strobe && !stsfs_is_toh(col);
    end
  end

endmodule : stsfs_ne_tx

`default_nettype wire

// ===== bench/stsfs_link_asserts.sv
// Wire-level checks on the byte stream between the two frame sequencer ends
`timescale 1ns/1ps
`default_nettype none

module stsfs_link_asserts #(
  parameter int FRAME_CYCLES = 5000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] data,
  input wire logic valid,
  input wire logic sof
);
  logic [9:0] n_bytes;
  logic [15:0] n_cycles;
  logic started;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////
  // Bytes seen since the last frame start, that byte included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      n_bytes <= 10'h000;
    end else if (valid && sof) begin
      n_bytes <= 10'h001;
    end else if (valid) begin
      n_bytes <= n_bytes + 10'h001;
    end
  end

  // Clock cycles since the last frame start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      n_cycles <= 16'h0000;
    end else begin
      n_cycles <= sof ? 16'h0001 : n_cycles + 16'h0001;
    end
  end

  // A frame start seen since reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else if (sof) begin
      started <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  a_sof_with_byte: assert property (sof |-> valid)
    else $error("frame start without a byte");
  a_sof_single_cycle: assert property (sof |=> !sof)
    else $error("frame start longer than one cycle");
  a_frame_byte_count: assert property (started && sof |-> n_bytes == 10'h32A)
    else $error("frame not 810 bytes");
  a_no_long_frame: assert property (valid && !sof |-> n_bytes < 10'h32A)
    else $error("byte beyond frame end");
  a_frame_period: assert property (started && sof |-> n_cycles == 16'(FRAME_CYCLES))
    else $error("frame period wrong");
  a_first_byte_a1: assert property (sof |-> data == 8'hF6)
    else $error("first byte wrong");
  a_second_byte_a2: assert property (valid && !sof && n_bytes == 10'h001 |-> data == 8'h28)
    else $error("second byte wrong");
  a_row_two_idle: assert property (valid && n_bytes == 10'h05A |-> data == 8'h00)
    else $error("row two start byte wrong");
  a_action_byte_idle: assert property (valid && n_bytes == 10'h110 |-> data == 8'h00)
    else $error("action byte not idle");
  a_pointer_flag_code: assert property (valid && n_bytes == 10'h10E |->
      (data[7:4] == 4'h6 || data[7:4] == 4'h9) && data[3:2] == 2'b00)
    else $error("pointer flag nibble wrong");
  a_byte_follows_sof: assert property (sof |-> ##[1:8] valid)
    else $error("gap after frame start");
endmodule : stsfs_link_asserts

`default_nettype wire

// ===== bench/tb_sts1_frame_sequencer.sv
// Testbench joining the transmitting and receiving frame sequencer ends
`timescale 1ns/1ps
`default_nettype none

module tb_sts1_frame_sequencer
  import stsfs_pkg::*;
;
  localparam int FRAME_CYCLES = 5000;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] payload_in = 8'h00;
  logic [9:0] ptr_in = 10'h064;
  logic ndf_in = 1'b0;
  logic take_out, byte_valid_out, sof_out, toh_out, h1_out, h2_out, h3_out;
  logic envelope_out, poh_out, payload_out, ptr_locked_out, inc_out, dec_out;
  logic ndf_out, frame_err_out;
  logic [7:0] byte_out;
  logic [3:0] row_out;
  logic [6:0] col_out;
  logic [9:0] ptr_out;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n_take = 0;

  stsfs_link_if link (.clk(clk_in), .rst_n(rst_n_in));

  stsfs_ne_tx #(.FRAME_CYCLES(FRAME_CYCLES)) u_stsfs_ne_tx (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .link(link), .payload_in(payload_in), .ptr_in(ptr_in),
    .ndf_in(ndf_in), .take_out(take_out));

  stsfs_seq_rx u_stsfs_seq_rx (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
    .byte_out(byte_out), .byte_valid_out(byte_valid_out), .sof_out(sof_out),
    .row_out(row_out), .col_out(col_out), .toh_out(toh_out), .h1_out(h1_out),
    .h2_out(h2_out), .h3_out(h3_out), .envelope_out(envelope_out), .poh_out(poh_out),
    .payload_out(payload_out), .ptr_locked_out(ptr_locked_out), .ptr_out(ptr_out),
    .inc_out(inc_out), .dec_out(dec_out), .ndf_out(ndf_out), .frame_err_out(frame_err_out));

  stsfs_link_asserts #(.FRAME_CYCLES(FRAME_CYCLES)) u_stsfs_link_asserts (.clk(clk_in),
    .rst_n(rst_n_in), .data(link.data), .valid(link.valid), .sof(link.sof));

  ////////////////////////////////////////////////////////////
  // Clock and counting envelope data
  always #12.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    #2;
    if (take_out === 1'b1) begin
      n_take++;
      payload_in = payload_in + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  // Wait a bounded time for the next received byte
  task automatic next_byte();
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (byte_valid_out !== 1'b1 && k < 40);
    cyc = cyc + k;
    chk_bit("byte_valid", 1'b1, byte_valid_out);
  endtask : next_byte

  task automatic to_sof();
    for (int i = 0; i < 900 && sof_out !== 1'b1; i++) begin
      next_byte();
    end
  endtask : to_sof

  task automatic wait_h2();
    next_byte();
    for (int i = 0; i < 900 && h2_out !== 1'b1; i++) begin
      next_byte();
    end
  endtask : wait_h2

  ////////////////////////////////////////////////////////////
  task automatic test_reset();
    repeat (19) @(posedge clk_in);
    #1;
    chk_bit("sof", 1'b0, sof_out);
    chk_bit("byte_valid", 1'b0, byte_valid_out);
    chk_val("position", 16'h0000, {5'h00, row_out, col_out});
    @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    $display("test_reset done");
  endtask : test_reset

  // Follow one whole frame byte by byte
  task automatic walk(input bit spe);
    logic [7:0] last;
    to_sof();
    cyc = 0;
    n_take = 0;
    for (int i = 0; i < 810; i++) begin
      if (i > 0) begin
        next_byte();
      end
      chk_val("row", 16'(i / 90), 16'(row_out));
      chk_val("col", 16'(i % 90), 16'(col_out));
      chk_bit("sof", i == 0, sof_out);
      chk_bit("toh", i % 90 < 3, toh_out);
      chk_bit("envelope", i % 90 >= 3, envelope_out);
      chk_bit("h1", i == 270, h1_out);
      chk_bit("h2", i == 271, h2_out);
      chk_bit("h3", i == 272, h3_out);
      chk_bit("frame_err", 1'b0, frame_err_out);
      if (i == 0) begin
        chk_val("first byte", 16'h00F6, 16'(byte_out));
      end
      if (i % 90 >= 3) begin
        if (i > 3) begin
          chk_val("env byte", 16'(8'(last + 8'h01)), 16'(byte_out));
        end
        last = byte_out;
      end
      if (spe) begin
        chk_bit("poh", i % 90 == 16, poh_out);
        chk_bit("payload", i % 90 > 2 && i % 90 != 16, payload_out);
      end
    end
    next_byte();
    chk_bit("next sof", 1'b1, sof_out);
    chk_val("frame cycles", 16'(FRAME_CYCLES), 16'(cyc));
    chk_val("take count", 16'h030F, 16'(n_take));
  endtask : walk

  task automatic test_geometry();
    walk(1'b0);
    chk_bit("locked", 1'b1, ptr_locked_out);
    chk_val("pointer", 16'h0064, 16'(ptr_out));
    $display("test_geometry done");
  endtask : test_geometry

  task automatic test_envelope();
    walk(1'b1);
    $display("test_envelope done");
  endtask : test_envelope

  // Send one pointer word and judge the event at the next pointer byte
  task automatic ptr_step(input logic [9:0] send, input logic ndf, input logic [2:0] ev,
                          input logic [9:0] exp);
    #1;
    ptr_in = send;
    ndf_in = ndf;
    wait_h2();
    chk_bit("inc", ev[2], inc_out);
    chk_bit("dec", ev[1], dec_out);
    chk_bit("ndf", ev[0], ndf_out);
    chk_val("pointer", 16'(exp), 16'(ptr_out));
  endtask : ptr_step

  task automatic test_events();
    wait_h2();
    ptr_step(10'h064 ^ 10'h2AA, 1'b0, 3'b100, 10'h065);
    ptr_step(10'h065 ^ 10'h155, 1'b0, 3'b010, 10'h064);
    ptr_step(10'h30E, 1'b1, 3'b001, 10'h30E);
    ptr_step(10'h30E ^ 10'h2AA, 1'b0, 3'b100, 10'h000);
    ptr_step(10'h000, 1'b0, 3'b000, 10'h000);
    $display("test_events done");
  endtask : test_events

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    test_reset();
    test_geometry();
    test_envelope();
    test_events();
    conclude();
  end

  // Watchdog against a stalled stream
  initial begin
    repeat (FRAME_CYCLES * 12) @(posedge clk_in);
    n_fail++;
    conclude();
  end
endmodule : tb_sts1_frame_sequencer

`default_nettype wire
